// ### rtl/adec_top.sv
// entry, editing and refresh timing of the ascii display controller
`timescale 1ns/1ns
`include "adec_params.svh"
module adec_top #(
  parameter int unsigned FRAME_CYCLES = `ADEC_FRAME_CYCLES,
  parameter bit          REDUCED_FONT = 1'b0
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  // host word port
  input  wire logic             chip_sel_b,
  input  wire logic [7:0]       data_in,
  input  wire logic [4:0]       addr_in,
  output logic                  ready,
  // character memory read for the refresh path
  input  wire logic [5:0]       disp_rd_pos,
  output logic [6:0]            disp_rd_char,
  // status
  output adec_pkg::adec_cfg_type cfg,
  output logic [5:0]            cursor_pos,
  output logic                  cursor_on,
  output logic                  insert_on,
  // refresh timing
  output logic [2:0]            scan_col,
  output logic                  col_strobe,
  output logic                  frame_strobe
);

  localparam int unsigned COL_CYCLES = FRAME_CYCLES / `ADEC_COLUMNS;
  localparam int unsigned READY_CYC  = `ADEC_READY_CYCLES;

  // ----------------------------------------------------------------
  // reset release and input synchronisers
  // ----------------------------------------------------------------
  logic       rst_meta_reg;
  logic       rst_n;
  logic       cs_meta_reg;
  logic       cs_sync_reg;
  logic       cs_prev_reg;
  logic [7:0] data_meta_reg;
  logic [7:0] data_sync_reg;
  logic [4:0] addr_meta_reg;
  logic [4:0] addr_sync_reg;

  // release reset through two flops
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_meta_reg   <= 1'b1;
      cs_sync_reg   <= 1'b1;
      cs_prev_reg   <= 1'b1;
      data_meta_reg <= 8'h00;
      data_sync_reg <= 8'h00;
      addr_meta_reg <= 5'h00;
      addr_sync_reg <= 5'h00;
    end else begin
      cs_meta_reg   <= chip_sel_b;
      cs_sync_reg   <= cs_meta_reg;
      cs_prev_reg   <= cs_sync_reg;
      data_meta_reg <= data_in;
      data_sync_reg <= data_meta_reg;
      addr_meta_reg <= addr_in;
      addr_sync_reg <= addr_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // word decode
  // ----------------------------------------------------------------
  adec_pkg::adec_mode_type new_mode;
  logic [3:0]              new_code;
  logic [5:0]              new_len;
  logic [5:0]              new_left;
  logic                    ctrl_ok;
  logic [5:0]              cur_len;
  logic [5:0]              cur_left;
  logic [6:0]              ch;
  logic                    font_ok;
  logic                    strobe;

  always_comb begin
    new_mode = adec_pkg::adec_mode_type'(data_sync_reg[`ADEC_MODE_HI:`ADEC_MODE_LO]);
    new_code = data_sync_reg[`ADEC_LEN_HI:0];
    new_len  = {new_code, 2'b00} + `ADEC_LEN_STEP;
    new_left = `ADEC_OFFSCREEN - new_len;
    ctrl_ok  = (new_mode == adec_pkg::ADEC_RAM) ? (new_code <= `ADEC_RAM_LEN_MAX)
                                                : (new_code <= `ADEC_LEN_MAX);
    ch       = data_sync_reg[6:0];
    font_ok  = !REDUCED_FONT || ((ch >= `ADEC_FONT_LO) && (ch <= `ADEC_FONT_HI));
  end

  assign strobe = cs_prev_reg & ~cs_sync_reg;

  // ----------------------------------------------------------------
  // entry state, memory and cursor
  // ----------------------------------------------------------------
  adec_pkg::adec_state_type state_reg;
  adec_pkg::adec_state_type state_next;
  adec_pkg::adec_cfg_type   cfg_reg;
  adec_pkg::adec_cfg_type   cfg_next;
  logic [9:0]               wait_reg;
  logic [9:0]               wait_next;
  logic [5:0]               cur_reg;
  logic [5:0]               cur_next;
  logic                     ins_reg;
  logic                     ins_next;
  logic [6:0]               mem_reg  [`ADEC_DEPTH];
  logic [6:0]               mem_next [`ADEC_DEPTH];
  logic [5:0]               pos;

  assign cur_len  = {cfg_reg.len_code, 2'b00} + `ADEC_LEN_STEP;
  assign cur_left = `ADEC_OFFSCREEN - cur_len;

  // next values of the entry logic
  always_comb begin
    state_next = state_reg;
    cfg_next   = cfg_reg;
    wait_next  = wait_reg;
    cur_next   = cur_reg;
    ins_next   = ins_reg;
    mem_next   = mem_reg;
    pos        = (cur_reg > `ADEC_LAST_POS) ? cur_left : cur_reg;
    case (state_reg)
      adec_pkg::ADEC_ST_INIT: begin
        if (wait_reg != 10'h000) begin
          wait_next = wait_reg - 10'h001;
        end else begin
          state_next = adec_pkg::ADEC_ST_IDLE;
          // strap word or default left 32
          if (data_sync_reg[`ADEC_TYPE_BIT] && ctrl_ok) begin
            cfg_next = '{mode: new_mode, len_code: new_code};
            cur_next = (new_mode == adec_pkg::ADEC_RIGHT) ? `ADEC_OFFSCREEN : new_left;
          end else begin
            cfg_next = '{mode: adec_pkg::ADEC_LEFT, len_code: `ADEC_DEF_LEN};
            cur_next = `ADEC_OFFSCREEN - ({`ADEC_DEF_LEN, 2'b00} + `ADEC_LEN_STEP);
          end
        end
      end
      adec_pkg::ADEC_ST_IDLE: begin
        // whole word handled in one cycle
        if (strobe) begin
          state_next = adec_pkg::ADEC_ST_BUSY;
          wait_next  = 10'(READY_CYC - 1);
          if (data_sync_reg[`ADEC_TYPE_BIT]) begin
            if (ctrl_ok) begin
              ins_next = 1'b0;
              cfg_next = '{mode: new_mode, len_code: new_code};
              if (!(new_mode == adec_pkg::ADEC_RAM && cfg_reg.mode != adec_pkg::ADEC_RAM)) begin
                for (int i = 0; i < `ADEC_DEPTH; i++) begin
                  mem_next[i] = `ADEC_SPACE;
                end
              end
              case (new_mode)
                adec_pkg::ADEC_RIGHT: cur_next = `ADEC_OFFSCREEN;
                adec_pkg::ADEC_RAM: begin
                  if (cfg_reg.mode == adec_pkg::ADEC_RAM) begin
                    cur_next = new_left;
                  end
                end
                default: begin
                  // ram cursor carries into left and block modes when at or right of the new left edge
                  if (!(cfg_reg.mode == adec_pkg::ADEC_RAM && cur_reg >= new_left)) begin
                    cur_next = new_left;
                  end
                end
              endcase
            end
          end else begin
            case (cfg_reg.mode)
              adec_pkg::ADEC_LEFT: begin
                if (ch == `ADEC_CMD_CLEAR) begin
                  for (int i = 0; i < `ADEC_DEPTH; i++) begin
                    mem_next[i] = `ADEC_SPACE;
                  end
                  cur_next = cur_left;
                  ins_next = 1'b0;
                end else if (ch == `ADEC_CMD_BACK) begin
                  if (cur_reg > cur_left) begin
                    cur_next = cur_reg - 6'h01;
                  end
                  ins_next = 1'b0;
                end else if (cur_reg < `ADEC_OFFSCREEN) begin
                  if (ch == `ADEC_CMD_ADVANCE) begin
                    cur_next = cur_reg + 6'h01;
                    ins_next = 1'b0;
                  end else if (ch == `ADEC_CMD_DELETE) begin
                    for (int i = 0; i < `ADEC_DEPTH - 1; i++) begin
                      if (6'(i) >= cur_reg) begin
                        mem_next[i] = mem_reg[i+1];
                      end
                    end
                    mem_next[`ADEC_DEPTH-1] = `ADEC_SPACE;
                    ins_next = 1'b0;
                  end else if (ch == `ADEC_CMD_INSERT) begin
                    ins_next = ~ins_reg;
                  end else if (font_ok) begin
                    // push cursor and right part along
                    if (ins_reg) begin
                      for (int i = 1; i < `ADEC_DEPTH; i++) begin
                        if (6'(i) > cur_reg) begin
                          mem_next[i] = mem_reg[i-1];
                        end
                      end
                    end
                    mem_next[cur_reg] = ch;
                    cur_next = cur_reg + 6'h01;
                  end
                end
              end
              adec_pkg::ADEC_RIGHT: begin
                cur_next = `ADEC_OFFSCREEN;
                if (ch == `ADEC_CMD_CLEAR) begin
                  for (int i = 0; i < `ADEC_DEPTH; i++) begin
                    mem_next[i] = `ADEC_SPACE;
                  end
                end else if (ch == `ADEC_CMD_BACK) begin
                  for (int i = 1; i < `ADEC_DEPTH; i++) begin
                    mem_next[i] = mem_reg[i-1];
                  end
                  mem_next[0] = `ADEC_SPACE;
                end else if (font_ok) begin
                  for (int i = 0; i < `ADEC_DEPTH - 1; i++) begin
                    mem_next[i] = mem_reg[i+1];
                  end
                  mem_next[`ADEC_DEPTH-1] = ch;
                end
              end
              adec_pkg::ADEC_BLOCK: begin
                if (font_ok) begin
                  mem_next[pos] = ch;
                  cur_next = (pos >= `ADEC_LAST_POS) ? cur_left : pos + 6'h01;
                end
              end
              adec_pkg::ADEC_RAM: begin
                // addressed write, cursor right of it
                if ((6'(addr_sync_reg) < cur_len) && font_ok) begin
                  mem_next[cur_left + 6'(addr_sync_reg)] = ch;
                  cur_next = cur_left + 6'(addr_sync_reg) + 6'h01;
                end
              end
              default: cur_next = cur_reg;
            endcase
          end
        end
      end
      adec_pkg::ADEC_ST_BUSY: begin
        // hold ready low for the pulse
        if (wait_reg == 10'h000) begin
          state_next = adec_pkg::ADEC_ST_IDLE;
        end else begin
          wait_next = wait_reg - 10'h001;
        end
      end
      default: state_next = adec_pkg::ADEC_ST_IDLE;
    endcase
  end

  // entry registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= adec_pkg::ADEC_ST_INIT;
      cfg_reg   <= '{mode: adec_pkg::ADEC_LEFT, len_code: `ADEC_DEF_LEN};
      wait_reg  <= `ADEC_INIT_WAIT;
      cur_reg   <= `ADEC_OFFSCREEN;
      ins_reg   <= 1'b0;
      for (int i = 0; i < `ADEC_DEPTH; i++) begin
        mem_reg[i] <= `ADEC_SPACE;
      end
    end else begin
      state_reg <= state_next;
      cfg_reg   <= cfg_next;
      wait_reg  <= wait_next;
      cur_reg   <= cur_next;
      ins_reg   <= ins_next;
      mem_reg   <= mem_next;
    end
  end

  // ready high only while waiting for a word
  assign ready = (state_reg == adec_pkg::ADEC_ST_IDLE);

  // ----------------------------------------------------------------
  // refresh timing and cursor blink
  // ----------------------------------------------------------------
  logic       col_tick;
  logic [2:0] col_reg;
  logic [2:0] col_next;
  logic       frame_reg;
  logic       frame_next;
  logic [5:0] blink_cnt_reg;
  logic [5:0] blink_cnt_next;
  logic       blink_reg;
  logic       blink_next;
  logic [6:0] rd_reg;
  logic [6:0] rd_next;

  // fixed column rate, whatever the length
  adec_divider #(
    .PERIOD (COL_CYCLES)
  ) u_col_div (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tick     (col_tick)
  );

  // column scan, frame pulse, blink and read port
  always_comb begin
    col_next       = col_reg;
    frame_next     = 1'b0;
    blink_cnt_next = blink_cnt_reg;
    blink_next     = blink_reg;
    if (col_tick) begin
      if (col_reg == 3'(`ADEC_COLUMNS - 1)) begin
        col_next   = 3'h0;
        frame_next = 1'b1;
      end else begin
        col_next = col_reg + 3'h1;
      end
    end
    if (frame_reg) begin
      if (blink_cnt_reg == `ADEC_BLINK_FRAMES) begin
        blink_cnt_next = 6'h00;
        blink_next     = ~blink_reg;
      end else begin
        blink_cnt_next = blink_cnt_reg + 6'h01;
      end
    end
    rd_next = (disp_rd_pos <= `ADEC_LAST_POS) ? mem_reg[disp_rd_pos] : `ADEC_SPACE;
  end

  // refresh registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      col_reg       <= 3'h0;
      frame_reg     <= 1'b0;
      blink_cnt_reg <= 6'h00;
      blink_reg     <= 1'b0;
      rd_reg        <= `ADEC_SPACE;
    end else begin
      col_reg       <= col_next;
      frame_reg     <= frame_next;
      blink_cnt_reg <= blink_cnt_next;
      blink_reg     <= blink_next;
      rd_reg        <= rd_next;
    end
  end

  // outputs
  assign scan_col     = col_reg;
  assign col_strobe   = col_tick;
  assign frame_strobe = frame_reg;
  assign disp_rd_char = rd_reg;
  assign cfg          = cfg_reg;
  assign cursor_pos   = cur_reg;
  assign insert_on    = ins_reg;
  assign cursor_on    = blink_reg && (cfg_reg.mode == adec_pkg::ADEC_LEFT);

endmodule : adec_top

// ### pkg/adec_params.svh
// named constants for the ascii display entry controller
`ifndef ADEC_PARAMS_SVH
`define ADEC_PARAMS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ADEC_CLK_HZ        20000000
`define ADEC_CLK_MHZ       20
`define ADEC_REFRESH_HZ    100
`define ADEC_FRAME_CYCLES  (`ADEC_CLK_HZ / `ADEC_REFRESH_HZ)
`define ADEC_COLUMNS       5
`define ADEC_READY_LOW_US  25
`define ADEC_READY_CYCLES  (`ADEC_READY_LOW_US * `ADEC_CLK_MHZ)
`define ADEC_INIT_WAIT     10'h002
`define ADEC_BLINK_FRAMES  6'h19

// ----------------------------------------------------------------
// word layout and limits
// ----------------------------------------------------------------
`define ADEC_TYPE_BIT      7
`define ADEC_MODE_HI       6
`define ADEC_MODE_LO       5
`define ADEC_LEN_HI        3
`define ADEC_LEN_MAX       4'hB
`define ADEC_RAM_LEN_MAX   4'h7
`define ADEC_DEF_LEN       4'h7
`define ADEC_DEPTH         48
`define ADEC_OFFSCREEN     6'h30
`define ADEC_LAST_POS      6'h2F
`define ADEC_LEN_STEP      6'h04

// ----------------------------------------------------------------
// character codes
// ----------------------------------------------------------------
`define ADEC_SPACE         7'h20
`define ADEC_FONT_LO       7'h20
`define ADEC_FONT_HI       7'h5F
`define ADEC_CMD_BACK      7'h08
`define ADEC_CMD_ADVANCE   7'h09
`define ADEC_CMD_CLEAR     7'h0C
`define ADEC_CMD_INSERT    7'h0E
`define ADEC_CMD_DELETE    7'h7F

`endif

// ### pkg/adec_pkg.sv
// types shared by the ascii display entry controller
package adec_pkg;

  // entry modes in control word order
  typedef enum logic [1:0] {
    ADEC_RAM,
    ADEC_LEFT,
    ADEC_RIGHT,
    ADEC_BLOCK
  } adec_mode_type;

  // active configuration
  typedef struct packed {
    adec_mode_type mode;
    logic [3:0]    len_code;
  } adec_cfg_type;

  // word handling states
  typedef enum logic [1:0] {
    ADEC_ST_INIT,
    ADEC_ST_IDLE,
    ADEC_ST_BUSY
  } adec_state_type;

endpackage : adec_pkg

// ### rtl/adec_divider.sv
// free-running divider giving a one-cycle tick every PERIOD cycles
`timescale 1ns/1ns
module adec_divider #(
  parameter int unsigned PERIOD = 40000
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // tick out
  output logic      tick
);

  localparam int W = $clog2(PERIOD);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic         tick_next;

  // count and wrap
  always_comb begin
    tick_next = (cnt_reg == W'(PERIOD - 1));
    cnt_next  = tick_next ? '0 : cnt_reg + 1'b1;
  end

  // registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick    <= tick_next;
    end
  end

endmodule : adec_divider

// ### dv/adec_host_model.sv
// host model that presents words to the controller through the select handshake
`timescale 1ns/1ns
module adec_host_model (
  // clock and handshake
  input  wire logic  core_clk,
  input  wire logic  ready,
  // word lines toward the controller
  output logic       chip_sel_b,
  output logic [7:0] data_in,
  output logic [4:0] addr_in
);
  // ----------------------------------------------------------------
  // idle levels at time zero
  // ----------------------------------------------------------------
  initial begin
    chip_sel_b = 1'b1;
    data_in    = 8'h00;
    addr_in    = 5'h00;
  end

  // strap word held across a reset release
  task automatic strap(input logic [7:0] w);
    @(negedge core_clk);
    data_in = w;
  endtask : strap

  // ----------------------------------------------------------------
  // one word per select strobe
  // ----------------------------------------------------------------
  task automatic send(input logic [7:0] w, input logic [4:0] a, input int hold);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 4000) begin
      @(negedge core_clk);
      n++;
    end
    @(negedge core_clk);
    data_in    = w;
    addr_in    = a;
    chip_sel_b = 1'b0;
    repeat (120) @(negedge core_clk);
    chip_sel_b = 1'b1;
    repeat (hold - 120) @(negedge core_clk);
    // released lines show the inverse
    data_in = ~w;
    addr_in = ~a;
  endtask : send
endmodule : adec_host_model

// ### dv/adec_top_properties.sv
// concurrent checks on the entry controller ports
`timescale 1ns/1ns
`include "adec_params.svh"
module adec_top_properties #(
  parameter int unsigned FRAME_CYCLES = `ADEC_FRAME_CYCLES
) (
  // clock and reset
  input wire logic                   core_clk,
  input wire logic                   rst_b,
  // host word port
  input wire logic                   chip_sel_b,
  input wire logic                   ready,
  // memory read
  input wire logic [5:0]             disp_rd_pos,
  input wire logic [6:0]             disp_rd_char,
  // status
  input wire adec_pkg::adec_cfg_type cfg,
  input wire logic [5:0]             cursor_pos,
  input wire logic                   cursor_on,
  input wire logic                   insert_on,
  // refresh timing
  input wire logic [2:0]             scan_col,
  input wire logic                   col_strobe,
  input wire logic                   frame_strobe
);
  localparam int unsigned COL_CYCLES = FRAME_CYCLES / `ADEC_COLUMNS;
  logic        armed_reg;
  logic        col_seen_reg;
  logic [9:0]  low_cnt_reg;
  logic [31:0] gap_cnt_reg;
  logic [5:0]  left_edge;

  // leftmost visible index for the configured length
  assign left_edge = 6'h30 - (({2'h0, cfg.len_code} + 6'h01) << 2);

  // ready-low span and column gap counters
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      armed_reg    <= 1'b0;
      col_seen_reg <= 1'b0;
      low_cnt_reg  <= 10'h000;
      gap_cnt_reg  <= 32'h0000_0000;
    end else begin
      armed_reg    <= armed_reg | ready;
      col_seen_reg <= col_seen_reg | col_strobe;
      low_cnt_reg  <= ready ? 10'h000 : low_cnt_reg + 10'h001;
      gap_cnt_reg  <= col_strobe ? 32'h0000_0000 : gap_cnt_reg + 32'h0000_0001;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // ----------------------------------------------------------------
  // handshake and state updates
  // ----------------------------------------------------------------
  ready_low_span_a: assert property (
    armed_reg && $rose(ready) |-> low_cnt_reg == `ADEC_READY_CYCLES)
    else $error("ready low span wrong");
  ready_low_max_a: assert property (
    armed_reg && !ready |-> low_cnt_reg < `ADEC_READY_CYCLES)
    else $error("ready stays low too long");
  select_take_a: assert property (
    ready && $fell(chip_sel_b) |-> ##[2:4] $fell(ready))
    else $error("select edge not taken");
  ready_cause_a: assert property (
    armed_reg && $fell(ready) |-> !chip_sel_b && $past(chip_sel_b, 6))
    else $error("ready fell without a select");
  cfg_hold_a: assert property (
    armed_reg && !$stable(cfg) |-> $fell(ready))
    else $error("config changed outside a take");
  cursor_hold_a: assert property (
    armed_reg && (!$stable(cursor_pos) || !$stable(insert_on)) |-> $fell(ready))
    else $error("cursor changed outside a take");
  left_cursor_a: assert property (
    cfg.mode == adec_pkg::ADEC_LEFT |-> cursor_pos >= left_edge && cursor_pos <= 6'h30)
    else $error("left cursor out of range");
  right_cursor_a: assert property (
    cfg.mode == adec_pkg::ADEC_RIGHT |-> cursor_pos == 6'h30)
    else $error("right cursor not offscreen");
  blink_left_a: assert property (
    cursor_on |-> cfg.mode == adec_pkg::ADEC_LEFT)
    else $error("cursor shown outside left mode");
  far_read_a: assert property (
    disp_rd_pos > 6'h2F |=> disp_rd_char == 7'h20)
    else $error("read beyond depth not space");

  // ----------------------------------------------------------------
  // refresh timing
  // ----------------------------------------------------------------
  col_period_a: assert property (
    col_seen_reg && col_strobe |-> gap_cnt_reg == COL_CYCLES - 1)
    else $error("column period wrong");
  frame_follow_a: assert property (
    frame_strobe |-> $past(col_strobe) && !col_strobe)
    else $error("frame strobe not after column strobe");
  col_step_a: assert property (
    col_strobe |=> scan_col == (($past(scan_col) == 3'h4) ? 3'h0 : $past(scan_col) + 3'h1))
    else $error("column step wrong");

  // main scenarios reached
  cover property (insert_on && $fell(ready));
  cover property (cfg.mode == adec_pkg::ADEC_RAM && $fell(ready));
  cover property (cfg.mode == adec_pkg::ADEC_LEFT && cursor_pos == 6'h30 && $fell(ready));
endmodule : adec_top_properties

bind adec_top adec_top_properties #(.FRAME_CYCLES(FRAME_CYCLES)) u_props (
  .core_clk(core_clk), .rst_b(rst_b), .chip_sel_b(chip_sel_b), .ready(ready),
  .disp_rd_pos(disp_rd_pos), .disp_rd_char(disp_rd_char), .cfg(cfg),
  .cursor_pos(cursor_pos), .cursor_on(cursor_on), .insert_on(insert_on),
  .scan_col(scan_col), .col_strobe(col_strobe), .frame_strobe(frame_strobe)
);

// ### dv/adec_top_tb.sv
// self-checking bench for the entry controller
`timescale 1ns/1ns
module adec_top_tb;
  // ----------------------------------------------------------------
  // signals and table of word rows
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] w;
    logic [4:0] a;
    logic [5:0] cfg;
    logic [5:0] cur;
    logic       ins;
    logic [5:0] pos;
    logic [6:0] ch;
  } adec_row_type;

  logic                   core_clk;
  logic                   rst_b;
  logic                   chip_sel_b;
  logic [7:0]             data_in;
  logic [4:0]             addr_in;
  logic                   ready;
  logic [5:0]             disp_rd_pos;
  logic [6:0]             disp_rd_char;
  logic [6:0]             lo_char;
  adec_pkg::adec_cfg_type cfg;
  logic [5:0]             cursor_pos;
  logic                   cursor_on;
  logic                   insert_on;
  int                     error_cnt;
  int                     checked;

  // word, address, then config, cursor, insert, read index, char
  adec_row_type rows [0:27] = '{
    '{8'h41,5'h00,6'h17,6'h11,1'b0,6'h10,7'h41}, '{8'h42,5'h00,6'h17,6'h12,1'b0,6'h11,7'h42},
    '{8'h08,5'h00,6'h17,6'h11,1'b0,6'h11,7'h42}, '{8'h0E,5'h00,6'h17,6'h11,1'b1,6'h11,7'h42},
    '{8'h43,5'h00,6'h17,6'h12,1'b1,6'h12,7'h42}, '{8'h08,5'h00,6'h17,6'h11,1'b0,6'h11,7'h43},
    '{8'h7F,5'h00,6'h17,6'h11,1'b0,6'h11,7'h42}, '{8'h09,5'h00,6'h17,6'h12,1'b0,6'h11,7'h42},
    '{8'h0C,5'h00,6'h17,6'h10,1'b0,6'h10,7'h20}, '{8'h5A,5'h00,6'h17,6'h11,1'b0,6'h10,7'h5A},
    '{8'hAC,5'h00,6'h17,6'h11,1'b0,6'h10,7'h5A}, '{8'h88,5'h00,6'h17,6'h11,1'b0,6'h10,7'h5A},
    '{8'h87,5'h00,6'h07,6'h11,1'b0,6'h10,7'h5A}, '{8'h51,5'h03,6'h07,6'h14,1'b0,6'h13,7'h51},
    '{8'h0C,5'h00,6'h07,6'h11,1'b0,6'h10,7'h0C}, '{8'h87,5'h00,6'h07,6'h10,1'b0,6'h10,7'h20},
    '{8'hE0,5'h00,6'h30,6'h2C,1'b0,6'h2C,7'h20}, '{8'h41,5'h00,6'h30,6'h2D,1'b0,6'h2C,7'h41},
    '{8'h42,5'h00,6'h30,6'h2E,1'b0,6'h2D,7'h42}, '{8'h43,5'h00,6'h30,6'h2F,1'b0,6'h2E,7'h43},
    '{8'h44,5'h00,6'h30,6'h2C,1'b0,6'h2F,7'h44}, '{8'h45,5'h00,6'h30,6'h2D,1'b0,6'h2C,7'h45},
    '{8'hC0,5'h00,6'h20,6'h30,1'b0,6'h2F,7'h20}, '{8'h41,5'h00,6'h20,6'h30,1'b0,6'h2F,7'h41},
    '{8'h42,5'h00,6'h20,6'h30,1'b0,6'h2E,7'h41}, '{8'h09,5'h00,6'h20,6'h30,1'b0,6'h2F,7'h09},
    '{8'h08,5'h00,6'h20,6'h30,1'b0,6'h2F,7'h42}, '{8'h0C,5'h00,6'h20,6'h30,1'b0,6'h2F,7'h20}
  };

  // ----------------------------------------------------------------
  // design, host model and clock
  // ----------------------------------------------------------------
  adec_top #(.FRAME_CYCLES(50), .REDUCED_FONT(1'b0)) uut (
    .core_clk(core_clk), .rst_b(rst_b), .chip_sel_b(chip_sel_b), .data_in(data_in),
    .addr_in(addr_in), .ready(ready), .disp_rd_pos(disp_rd_pos),
    .disp_rd_char(disp_rd_char), .cfg(cfg), .cursor_pos(cursor_pos),
    .cursor_on(cursor_on), .insert_on(insert_on), .scan_col(), .col_strobe(),
    .frame_strobe()
  );
  // reduced-font twin fed the same words
  adec_top #(.REDUCED_FONT(1'b1)) uut_lo (
    .core_clk(core_clk), .rst_b(rst_b), .chip_sel_b(chip_sel_b), .data_in(data_in),
    .addr_in(addr_in), .ready(), .disp_rd_pos(disp_rd_pos), .disp_rd_char(lo_char), .cfg(),
    .cursor_pos(), .cursor_on(), .insert_on(), .scan_col(), .col_strobe(), .frame_strobe()
  );
  adec_host_model u_host (
    .core_clk(core_clk), .ready(ready), .chip_sel_b(chip_sel_b), .data_in(data_in),
    .addr_in(addr_in)
  );

  // 20 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [6:0] got, input logic [6:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // registered read: index at one falling edge, char settled at the next
  task automatic rd_chk(input logic [5:0] pos, input logic [6:0] exp);
    @(negedge core_clk);
    disp_rd_pos = pos;
    @(negedge core_clk);
    chk(disp_rd_char, exp);
  endtask : rd_chk

  task automatic wait_ready();
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
  endtask : wait_ready

  function automatic int hold_for(input adec_pkg::adec_mode_type m);
    case (m)
      adec_pkg::ADEC_LEFT:  return 3000;
      adec_pkg::ADEC_RIGHT: return 2100;
      adec_pkg::ADEC_RAM:   return 2600;
      default:              return 1100;
    endcase
  endfunction : hold_for

  task automatic tally_and_finish();
    if (error_cnt == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  // watchdog sized above the expected run of about 84600 cycles
  initial begin
    repeat (100000) @(posedge core_clk);
    error_cnt++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b       = 1'b0;
    disp_rd_pos = 6'h00;
    error_cnt   = 0;
    checked     = 0;
    repeat (6) @(negedge core_clk);
    rst_b = 1'b1;
    wait_ready();
    chk({1'b0, cfg}, 7'h17);
    chk({1'b0, cursor_pos}, 7'h10);
    // table rows: left editing, control words, ram, block and right entry
    foreach (rows[i]) begin
      u_host.send(rows[i].w, rows[i].a, hold_for(cfg.mode));
      chk({1'b0, cfg}, {1'b0, rows[i].cfg});
      chk({1'b0, cursor_pos}, {1'b0, rows[i].cur});
      chk({6'h00, insert_on}, {6'h00, rows[i].ins});
      rd_chk(rows[i].pos, rows[i].ch);
    end
    // read beyond the memory depth
    rd_chk(6'h30, 7'h20);
    // strap a left length-four control word across a second reset
    u_host.strap(8'hA0);
    rst_b = 1'b0;
    repeat (6) @(negedge core_clk);
    rst_b = 1'b1;
    wait_ready();
    chk({1'b0, cfg}, 7'h10);
    chk({1'b0, cursor_pos}, 7'h2C);
    // lower case, fill, refused character, backspace
    u_host.send(8'h61, 5'h00, 3000);
    repeat (3) u_host.send(8'h41, 5'h00, 3000);
    chk({1'b0, cursor_pos}, 7'h30);
    u_host.send(8'h58, 5'h00, 3000);
    chk({1'b0, cursor_pos}, 7'h30);
    rd_chk(6'h2F, 7'h41);
    chk(lo_char, 7'h58);
    u_host.send(8'h08, 5'h00, 3000);
    chk({1'b0, cursor_pos}, 7'h2F);
    tally_and_finish();
  end
endmodule : adec_top_tb
